// File: logic/pleb_defines.vh
// constants for the pwm leading-edge blanking block
// assumes inclusion by bare name from logic/ files
`ifndef PLEB_DEFINES_VH
`define PLEB_DEFINES_VH
// ************************************
// register map (byte addresses)
// ************************************
`define PLEB_ADDR_CONTROL 4'h0
`define PLEB_ADDR_PERIOD 4'h4
`define PLEB_ADDR_STATUS 4'h8
`define PLEB_CONTROL_RESET 16'h0000
`define PLEB_CONTROL_WMASK 16'hfc3f
`define PLEB_PERIOD_RESET 16'h0000
// ************************************
// control field positions
// ************************************
`define PLEB_HI_RISE 15
`define PLEB_HI_FALL 14
`define PLEB_LO_RISE 13
`define PLEB_LO_FALL 12
`define PLEB_FAULT_EN 11
`define PLEB_CURLIM_EN 10
`define PLEB_EXT_HIGH 5
`define PLEB_EXT_LOW 4
`define PLEB_HI_HIGH 3
`define PLEB_HI_LOW 2
`define PLEB_LO_HIGH 1
`define PLEB_LO_LOW 0
// ************************************
// bus answers
// ************************************
`define PLEB_RESP_OKAY 2'b00
`define PLEB_RESP_SLVERR 2'b10
`endif

// File: logic/pleb_state_blank.v
// state blanking combiner for one pwm pair
// assumes all inputs synchronous to aclk
`include "pleb_defines.vh"
module pleb_state_blank (
	input wire [15:0] ctrl,
	input wire pwm_high_side_out,
	input wire pwm_low_side_out,
	input wire ext_blank_sig,
	output wire state_blank
);
	// each level enable masks only while its level holds
	assign state_blank = (ctrl[`PLEB_HI_HIGH] & pwm_high_side_out) |
		(ctrl[`PLEB_HI_LOW] & ~pwm_high_side_out) |
		(ctrl[`PLEB_LO_HIGH] & pwm_low_side_out) |
		(ctrl[`PLEB_LO_LOW] & ~pwm_low_side_out) |
		(ctrl[`PLEB_EXT_HIGH] & ext_blank_sig) |
		(ctrl[`PLEB_EXT_LOW] & ~ext_blank_sig);
endmodule

// File: logic/pleb_top.v
// leading-edge and state blanking for one pwm pair, axi4-lite register slave
// assumes pwm outputs, fault and current-limit inputs synchronous to aclk;
// ext_blank_sig already selected by the auxiliary control logic;
// the blanking period register counts aclk cycles, not pwm periods;
// the bus master keeps at most one write and one read in flight
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`include "pleb_defines.vh"
module pleb_top (
	input wire aclk,
	input wire aresetn,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire pwm_high_side_out,
	input wire pwm_low_side_out,
	input wire ext_blank_sig,
	input wire fault_in,
	input wire curlim_in,
	output wire fault_out,
	output wire curlim_out,
	output wire blank_active
);
	// ************************************
	// register state
	// ************************************
	reg [15:0] leb_control_q;
	reg [15:0] period_q;
	reg aw_full_q;
	reg w_full_q;
	reg [3:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	reg rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0] rresp_q;
	reg hi_prev_q;
	reg lo_prev_q;
	reg [15:0] leb_cnt_q;
	reg fault_out_q;
	reg curlim_out_q;
	wire state_blank;
	wire do_write;
	wire edge_trig;
	wire leb_window;
	wire [3:0] trig_en;
	wire [3:0] trig_hit;
	wire hi_rise_trig_en;
	wire hi_fall_trig_en;
	wire lo_rise_trig_en;
	wire lo_fall_trig_en;
	wire fault_blank_en;
	wire curlim_blank_en;

	// ************************************
	// helper functions
	// ************************************
	// level change on one pin, in the direction asked for
	function edge_seen;
		input now_lvl;
		input prev_lvl;
		input rising;
		begin
			edge_seen = rising ? (now_lvl & ~prev_lvl) : (~now_lvl & prev_lvl);
		end
	endfunction

	// an input passes unless its window or any state blank covers it
	function masked;
		input sig;
		input window;
		input en;
		input state;
		begin
			masked = sig & ~((window & en) | state);
		end
	endfunction

	// status snapshot, upper bits read as zero
	function [31:0] status_word;
		input window;
		input state;
		input flt;
		input cur;
		input [15:0] cnt;
		begin
			status_word = {12'h000, window, state, flt, cur, cnt};
		end
	endfunction

	function [15:0] merge16;
		input [15:0] old;
		input [31:0] data;
		input [3:0] strb;
		begin
			merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
		end
	endfunction

	function mapped;
		input [3:0] addr;
		begin
			mapped = (addr == `PLEB_ADDR_CONTROL) || (addr == `PLEB_ADDR_PERIOD) ||
				(addr == `PLEB_ADDR_STATUS);
		end
	endfunction

	// ************************************
	// control fields
	// ************************************
	// named taps keep the datapath readable against the bit map
	assign hi_rise_trig_en = leb_control_q[`PLEB_HI_RISE];
	assign hi_fall_trig_en = leb_control_q[`PLEB_HI_FALL];
	assign lo_rise_trig_en = leb_control_q[`PLEB_LO_RISE];
	assign lo_fall_trig_en = leb_control_q[`PLEB_LO_FALL];
	assign fault_blank_en = leb_control_q[`PLEB_FAULT_EN];
	assign curlim_blank_en = leb_control_q[`PLEB_CURLIM_EN];

	// ************************************
	// axi4-lite write path
	// ************************************
	// address and data may land in either order; held until response drains
	assign s_axi_awready = ~aw_full_q & ~bvalid_q;
	assign s_axi_wready = ~w_full_q & ~bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign do_write = aw_full_q & w_full_q & ~bvalid_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= 4'h0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `PLEB_RESP_OKAY;
			leb_control_q <= `PLEB_CONTROL_RESET;
			period_q <= `PLEB_PERIOD_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				awaddr_q <= {s_axi_awaddr[3:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= mapped(awaddr_q) ? `PLEB_RESP_OKAY : `PLEB_RESP_SLVERR;
				if (awaddr_q == `PLEB_ADDR_CONTROL) begin
					// unimplemented bits stay zero
					leb_control_q <= merge16(leb_control_q, wdata_q, wstrb_q) & `PLEB_CONTROL_WMASK;
				end
				if (awaddr_q == `PLEB_ADDR_PERIOD) begin
					period_q <= merge16(period_q, wdata_q, wstrb_q);
				end
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ************************************
	// axi4-lite read path
	// ************************************
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `PLEB_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q <= mapped(s_axi_araddr) ? `PLEB_RESP_OKAY : `PLEB_RESP_SLVERR;
			case ({s_axi_araddr[3:2], 2'b00})
				`PLEB_ADDR_CONTROL: rdata_q <= {16'h0000, leb_control_q};
				`PLEB_ADDR_PERIOD: rdata_q <= {16'h0000, period_q};
				`PLEB_ADDR_STATUS: rdata_q <= status_word(leb_window, state_blank,
					fault_out_q, curlim_out_q, leb_cnt_q);
				default: rdata_q <= 32'h00000000;
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ************************************
	// edge detection and blanking counter
	// ************************************
	// one enable per edge kind, msb first as in the control word
	assign trig_en = {hi_rise_trig_en, hi_fall_trig_en, lo_rise_trig_en, lo_fall_trig_en};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_trig
			// odd slots watch rising edges; slots 3:2 the high side, 1:0 the low side
			assign trig_hit[gi] = trig_en[gi] & edge_seen(gi >= 2 ? pwm_high_side_out : pwm_low_side_out,
				gi >= 2 ? hi_prev_q : lo_prev_q, (gi % 2) == 1);
		end
	endgenerate

	// all enabled edges share the one counter, so the latest edge wins
	assign edge_trig = |trig_hit;

	// window covers the trigger cycle plus period_q further cycles
	assign leb_window = edge_trig | (leb_cnt_q != 16'h0000);

	always @(posedge aclk) begin
		if (!aresetn) begin
			hi_prev_q <= 1'b0;
			lo_prev_q <= 1'b0;
			leb_cnt_q <= 16'h0000;
		end else begin
			hi_prev_q <= pwm_high_side_out;
			lo_prev_q <= pwm_low_side_out;
			// a new edge restarts the count even mid-window
			if (edge_trig) begin
				leb_cnt_q <= period_q;
			end else if (leb_cnt_q != 16'h0000) begin
				leb_cnt_q <= leb_cnt_q - 16'h0001;
			end
		end
	end

	// ************************************
	// state blanking
	// ************************************
	pleb_state_blank u_state_blank (
		.ctrl(leb_control_q),
		.pwm_high_side_out(pwm_high_side_out),
		.pwm_low_side_out(pwm_low_side_out),
		.ext_blank_sig(ext_blank_sig),
		.state_blank(state_blank)
	);

	// ************************************
	// masked outputs
	// ************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			fault_out_q <= 1'b0;
			curlim_out_q <= 1'b0;
		end else begin
			// registered so downstream fault logic sees no combinational glitch
			fault_out_q <= masked(fault_in, leb_window, fault_blank_en, state_blank);
			curlim_out_q <= masked(curlim_in, leb_window, curlim_blank_en, state_blank);
		end
	end

	assign fault_out = fault_out_q;
	assign curlim_out = curlim_out_q;
	assign blank_active = leb_window | state_blank;
endmodule

// File: test/pleb_checker.sv
// assertions on the blanking block's bus answers and masked outputs
// assumes binding to pleb_top, one clock aclk, sync reset aresetn
// ports are grouped to save room; each still matches its design port
module pleb_checker (
	input logic aclk, aresetn,
	input logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic s_axi_rvalid, s_axi_rready,
	input logic fault_in, curlim_in, fault_out, curlim_out, blank_active
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_fault_pass: assert property (fault_out |-> $past(fault_in))
		else $error("fault_out high without fault_in");
	a_curlim_pass: assert property (curlim_out |-> $past(curlim_in))
		else $error("curlim_out high without curlim_in");
	// a masked input must have been inside some blanking condition
	a_fault_mask: assert property ($past(aresetn) && $past(fault_in) && !fault_out |-> $past(blank_active))
		else $error("fault masked while nothing blanks");
	a_curlim_mask: assert property ($past(aresetn) && $past(curlim_in) && !curlim_out |-> $past(blank_active))
		else $error("curlim masked while nothing blanks");
	// the write lands one edge after both are taken, bvalid shows one edge later
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("no write response two cycles after both taken");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read data one cycle after address");
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before rready");
endmodule

bind pleb_top pleb_checker chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .fault_in, .curlim_in, .fault_out, .curlim_out, .blank_active);

// File: test/testbench.sv
// self-checking bench for pleb_top through its axi4-lite registers
// assumes the logic/ files compiled first; status word shows the outputs
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [31:0] e, m; logic [1:0] r;} pleb_note_t;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hi, lo, ext, flt, cl, st;
	logic [3:0] awaddr, araddr;
	logic [31:0] wdata, x;
	wire awready, wready, bvalid, arready, rvalid, fault_out, curlim_out, blank_active;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	pleb_note_t notes[$];
	pleb_note_t n;
	int failures, total_checks;
	pleb_top dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_high_side_out(hi), .pwm_low_side_out(lo),
		.ext_blank_sig(ext), .fault_in(flt), .curlim_in(cl), .fault_out, .curlim_out, .blank_active);
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				total_checks++;
				if (bresp !== r) begin
					failures++;
					$display("[FAIL] bresp expected %h seen %h", r, bresp);
				end
			end
		end while (awvalid || wvalid || bready);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e, m, input logic [1:0] r);
		notes.push_back('{e, m, r});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) rready <= 1'b0;
		end while (arvalid || rready);
	endtask
	always @(posedge aclk) begin
		if (rvalid && rready) begin
			n = notes.pop_front();
			total_checks++;
			if (((rdata ^ n.e) & n.m) !== 32'h0 || rresp !== n.r) begin
				failures++;
				$display("[FAIL] rdata/rresp expected %h/%h seen %h/%h", n.e & n.m, n.r, rdata & n.m, rresp);
			end
		end
	end
	task automatic conclude;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ************************************
	// main sequence
	// ************************************
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		{hi, lo, ext, flt, cl} = 5'h03;
		x = 32'd80648;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(4'h0, 32'h0, '1, 2'b00);
		rd(4'h4, 32'h0, '1, 2'b00);
		rd(4'hc, 32'h0, '1, 2'b10);
		wr(4'hc, 32'hffff, 2'b10);
		repeat (4) begin
			x = xs(x);
			wr(4'h0, x);
			rd(4'h0, x & 32'hfc3f, '1, 2'b00);
		end
		// every state enable against both levels of its signal
		for (int b = 0; b < 6; b++) begin
			for (int v = 0; v < 2; v++) begin
				{hi, lo, ext} <= {3{v[0]}};
				wr(4'h0, 32'h1 << b);
				repeat (2) @(posedge aclk);
				st = (b % 2) == v;
				rd(4'h8, {12'h0, 1'b0, st, !st, !st, 16'h0}, 32'h000f0000, 2'b00);
			end
		end
		wr(4'h4, 32'd20);
		// only the opposite edge enabled, then each edge enabled
		for (int t = 0; t < 4; t++) begin
			for (int e = 0; e < 2; e++) begin
				{hi, lo, ext} <= {t[0], t[0], 1'b0};
				repeat (25) @(posedge aclk);
				wr(4'h0, (32'h8000 >> (e ? t : t ^ 1)) | (t[0] ? 32'h0400 : 32'h0800));
				if (t < 2) hi <= !t[0];
				else lo <= !t[0];
				repeat (2) @(posedge aclk);
				rd(4'h8, {12'h0, e[0], 1'b0, !(e[0] & !t[0]), !(e[0] & t[0]), 16'h0}, 32'h000f0000, 2'b00);
			end
		end
		conclude;
	end
	initial begin
		#40000;
		failures++;
		conclude;
	end
endmodule
